// ==== include/sep_cfg.svh ====
// sep_cfg.svh: constants of the serial memory front end
`ifndef SEP_CFG_SVH
`define SEP_CFG_SVH

// ==========================================================================
// array geometry
`define SEP_MEM_DEPTH   16384
`define SEP_ID_DEPTH    64
`define SEP_ADDR_W      14
`define SEP_PAGE_W      6
`define SEP_BYTE_W      8
`define SEP_ADDR_BYTES  2'h2

// ==========================================================================
// instruction codes
`define SEP_OP_WRITE    8'h02
`define SEP_OP_READ     8'h03
`define SEP_OP_WR_ID    8'h82
`define SEP_OP_RD_ID    8'h83
`define SEP_OP_LOCK_ID  8'h84

// ==========================================================================
// serial framing and timing
`define SEP_LAST_BIT    3'h7
`define SEP_BUF_DEPTH   2'h2
`define SEP_TW_NS       5000000
`define SEP_CLK_NS      50
`define SEP_TW_W        17

`endif

// ==== include/sep_pkg.sv ====
// sep_pkg.sv: types of the serial memory front end
`include "sep_cfg.svh"

package sep_pkg;

    // ======================================================================
    // word handed from the link domain to the core
    typedef enum logic [1:0] {
        SEP_K_MEM,
        SEP_K_ID,
        SEP_K_LOCK
    } sep_kind_t;

    typedef struct packed {
        sep_kind_t                 kind;
        logic [`SEP_ADDR_W-1:0]    addr;
        logic [`SEP_BYTE_W-1:0]    data;
    } sep_word_t;

    // ======================================================================
    // link-side frame states
    typedef enum logic [2:0] {
        SEP_L_CMD,
        SEP_L_ADDR,
        SEP_L_WDATA,
        SEP_L_RDATA,
        SEP_L_IGNORE
    } sep_lstate_t;

endpackage : sep_pkg

// ==== hw/sep_eeprom_front.sv ====
// sep_eeprom_front.sv: serial memory device front end and storage
`timescale 1ns/1ps
`include "sep_cfg.svh"

module sep_eeprom_front #(
    parameter int MEM_DEPTH    = `SEP_MEM_DEPTH,
    parameter int ID_DEPTH     = `SEP_ID_DEPTH,
    parameter int WRITE_CYCLES =
        (`SEP_TW_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS
) (
    // system clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // serial pins
    input  wire logic i_sclk,
    input  wire logic i_mosi,
    input  wire logic i_cs_n,
    input  wire logic i_hold_n,
    output logic      o_miso,
    output logic      o_miso_oe_n,
    // device state
    output logic      o_active,
    output logic      o_standby,
    output logic      o_write_busy,
    output logic      o_id_locked
);
    import sep_pkg::*;

    // ======================================================================
    // state types
    typedef struct packed {
        sep_lstate_t                st;
        logic [2:0]                 bitcnt;
        logic [`SEP_BYTE_W-2:0]     sh;
        logic [`SEP_BYTE_W-1:0]     cmd;
        logic [1:0]                 abytes;
        logic [`SEP_ADDR_W-1:0]     addr;
    } sep_rise_t;

    typedef struct packed {
        sep_word_t                  word;
        logic                       tgl;
    } sep_xfer_t;

    typedef struct packed {
        logic                       q;
        logic                       drive;
    } sep_fall_t;

    typedef struct packed {
        logic                       cs_meta;
        logic                       cs_sync;
        logic                       tgl_meta;
        logic                       tgl_sync;
        logic                       tgl_seen;
        logic                       armed;
        sep_word_t [1:0]            buf_w;
        logic [1:0]                 cnt;
        logic                       wr_pend;
        logic [`SEP_TW_W-1:0]       timer;
        logic                       locked;
        logic [MEM_DEPTH-1:0][`SEP_BYTE_W-1:0] mem;
        logic [ID_DEPTH-1:0][`SEP_BYTE_W-1:0]  idmem;
    } sep_core_t;

    sep_rise_t              rise_q;
    sep_rise_t              rise_d;
    sep_xfer_t              xfer_q;
    sep_xfer_t              xfer_d;
    sep_fall_t              fall_q;
    sep_fall_t              fall_d;
    sep_core_t              core_q;
    sep_core_t              core_d;
    logic                   link_rst;
    logic [`SEP_BYTE_W-1:0] byte_in;
    logic [`SEP_BYTE_W-1:0] rd_byte;
    logic                   is_read;
    logic                   is_id;
    logic                   fill_valid;
    logic                   fill_ready;
    logic                   drain_valid;
    logic                   drain_ready;

    // ======================================================================
    // link reset: deselect or not yet armed clears the frame
    assign link_rst = i_rst | i_cs_n | ~core_q.armed;

    assign is_read  = (rise_q.cmd == `SEP_OP_READ)
                    | (rise_q.cmd == `SEP_OP_RD_ID);
    assign is_id    = (rise_q.cmd == `SEP_OP_RD_ID)
                    | (rise_q.cmd == `SEP_OP_WR_ID);

    // storage is quasi-static while a frame reads it
    assign rd_byte  = is_id
                    ? core_q.idmem[rise_q.addr[`SEP_PAGE_W-1:0]]
                    : core_q.mem[rise_q.addr];

    // ======================================================================
    // rising edge: shift in, decode frame
    always_comb
    begin
        byte_in = {rise_q.sh, i_mosi};
        rise_d  = rise_q;
        xfer_d  = xfer_q;
        if (i_hold_n)
        begin
            rise_d.sh     = byte_in[`SEP_BYTE_W-2:0];
            rise_d.bitcnt = rise_q.bitcnt + 3'h1;
            if (rise_q.bitcnt == `SEP_LAST_BIT)
            begin
                case (rise_q.st)
                    SEP_L_CMD:
                    begin
                        rise_d.cmd = byte_in;
                        case (byte_in)
                            `SEP_OP_READ,
                            `SEP_OP_WRITE,
                            `SEP_OP_RD_ID,
                            `SEP_OP_WR_ID:
                                rise_d.st = SEP_L_ADDR;
                            `SEP_OP_LOCK_ID:
                            begin
                                xfer_d.word.kind = SEP_K_LOCK;
                                xfer_d.word.addr = '0;
                                xfer_d.word.data = '0;
                                xfer_d.tgl       = ~xfer_q.tgl;
                                rise_d.st        = SEP_L_IGNORE;
                            end
                            default:
                                rise_d.st = SEP_L_IGNORE;
                        endcase
                    end
                    SEP_L_ADDR:
                    begin
                        rise_d.addr   = {rise_q.addr[`SEP_ADDR_W
                                         -`SEP_BYTE_W-1:0],
                                         byte_in};
                        rise_d.abytes = rise_q.abytes + 2'h1;
                        if (rise_q.abytes == `SEP_ADDR_BYTES - 2'h1)
                        begin
                            rise_d.st = is_read ? SEP_L_RDATA
                                                : SEP_L_WDATA;
                        end
                    end
                    SEP_L_WDATA:
                    begin
                        xfer_d.word.kind = is_id ? SEP_K_ID : SEP_K_MEM;
                        xfer_d.word.addr = rise_q.addr;
                        xfer_d.word.data = byte_in;
                        xfer_d.tgl       = ~xfer_q.tgl;
                        // writes roll over inside the page
                        rise_d.addr[`SEP_PAGE_W-1:0] =
                            rise_q.addr[`SEP_PAGE_W-1:0] + 6'h1;
                    end
                    SEP_L_RDATA:
                    begin
                        if (is_id)
                            rise_d.addr[`SEP_PAGE_W-1:0] =
                                rise_q.addr[`SEP_PAGE_W-1:0] + 6'h1;
                        else
                            rise_d.addr = rise_q.addr + 14'h1;
                    end
                    default:
                        rise_d.st = SEP_L_IGNORE;
                endcase
            end
        end
    end

    always_ff @(posedge i_sclk or posedge link_rst)
    begin
        if (link_rst)
            rise_q <= '0;
        else
            rise_q <= rise_d;
    end

    // handed word survives deselect so the core can still take it
    always_ff @(posedge i_sclk or posedge i_rst)
    begin
        if (i_rst)
            xfer_q <= '0;
        else
            xfer_q <= xfer_d;
    end

    // ======================================================================
    // falling edge: shift out
    always_comb
    begin
        fall_d = fall_q;
        if (i_hold_n)
        begin
            fall_d.q     = rd_byte[~rise_q.bitcnt];
            fall_d.drive = (rise_q.st == SEP_L_RDATA);
        end
    end

    always_ff @(negedge i_sclk or posedge link_rst)
    begin
        if (link_rst)
            fall_q <= '0;
        else
            fall_q <= fall_d;
    end

    assign o_miso      = fall_q.q;
    // released when deselected, paused or outside read data
    assign o_miso_oe_n = ~(fall_q.drive & i_hold_n & ~i_cs_n
                           & core_q.armed);

    // ======================================================================
    // core: synchronisers, two-entry buffer, storage, write cycle
    assign fill_valid  = core_q.tgl_sync != core_q.tgl_seen;
    assign fill_ready  = core_q.cnt != `SEP_BUF_DEPTH;
    assign drain_valid = core_q.cnt != 2'h0;
    assign drain_ready = core_q.timer == '0;

    always_comb
    begin
        core_d          = core_q;
        core_d.cs_meta  = i_cs_n;
        core_d.cs_sync  = core_q.cs_meta;
        core_d.tgl_meta = xfer_q.tgl;
        core_d.tgl_sync = core_q.tgl_meta;
        if (core_q.cs_sync)
            core_d.armed = 1'b1;
        if (core_q.timer != '0)
            core_d.timer = core_q.timer - `SEP_TW_W'(1);
        // drain head into storage
        if (drain_valid && drain_ready)
        begin
            case (core_q.buf_w[0].kind)
                SEP_K_MEM:
                begin
                    core_d.mem[core_q.buf_w[0].addr] =
                        core_q.buf_w[0].data;
                    core_d.wr_pend = 1'b1;
                end
                SEP_K_ID:
                begin
                    if (!core_q.locked)
                    begin
                        core_d.idmem[core_q.buf_w[0].addr[`SEP_PAGE_W-1:0]]
                            = core_q.buf_w[0].data;
                        core_d.wr_pend = 1'b1;
                    end
                end
                SEP_K_LOCK:
                    core_d.locked = 1'b1;
                default:
                    core_d.locked = core_q.locked;
            endcase
            core_d.buf_w[0] = core_q.buf_w[1];
        end
        // fill tail from the link
        if (fill_valid && fill_ready)
        begin
            core_d.tgl_seen = core_q.tgl_sync;
            if (drain_valid && drain_ready)
                core_d.buf_w[core_q.cnt - 2'h1] = xfer_q.word;
            else
                core_d.buf_w[core_q.cnt[0]] = xfer_q.word;
        end
        core_d.cnt = core_q.cnt
                   + {1'b0, fill_valid & fill_ready}
                   - {1'b0, drain_valid & drain_ready};
        // deselect with all words stored starts the write cycle
        if (core_q.cs_sync && core_q.wr_pend && !drain_valid
            && !fill_valid)
        begin
            core_d.wr_pend = 1'b0;
            core_d.timer   = `SEP_TW_W'(WRITE_CYCLES);
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            core_q <= '0;
        else
            core_q <= core_d;
    end

    // ======================================================================
    // device state outputs
    assign o_active     = ~core_q.cs_sync & core_q.armed;
    assign o_standby    = ~o_active & (core_q.timer == '0)
                        & ~core_q.wr_pend;
    assign o_write_busy = core_q.timer != '0;
    assign o_id_locked  = core_q.locked;

endmodule : sep_eeprom_front

// ==== verif/sep_eeprom_front_props.sv ====
// sep_eeprom_front_props.sv: pin assertions of the serial memory front end
`timescale 1ns/1ps
module sep_eeprom_front_props #(
    parameter int WRITE_CYCLES = 20
) (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // serial pins
    input  wire logic i_sclk,
    input  wire logic i_mosi,
    input  wire logic i_cs_n,
    input  wire logic i_hold_n,
    input  wire logic o_miso,
    input  wire logic o_miso_oe_n,
    // device state
    input  wire logic o_active,
    input  wire logic o_standby,
    input  wire logic o_write_busy,
    input  wire logic o_id_locked
);
    logic rise_bit_q;
    int   busy_cnt_q;
    // ======================================================================
    // helpers
    always_ff @(posedge i_sclk or posedge i_rst)
        if (i_rst)
            rise_bit_q <= 1'b0;
        else
            rise_bit_q <= o_miso;
    always_ff @(posedge i_clock or posedge i_rst)
        if (i_rst)
            busy_cnt_q <= 0;
        else
            busy_cnt_q <= o_write_busy ? busy_cnt_q + 1 : 0;
    // ======================================================================
    // assertions
    a_desel_released: assert property (@(posedge i_clock) disable iff (i_rst)
        i_cs_n |-> o_miso_oe_n) else $error("output driven while deselected");
    a_pause_released: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_hold_n |-> o_miso_oe_n) else $error("output driven in pause");
    a_active_standby: assert property (@(posedge i_clock) disable iff (i_rst)
        o_active |-> !o_standby) else $error("active and standby");
    a_busy_standby: assert property (@(posedge i_clock) disable iff (i_rst)
        o_write_busy |-> !o_standby) else $error("standby in write");
    a_desel_inactive: assert property (@(posedge i_clock) disable iff (i_rst)
        $rose(i_cs_n) |-> ##[1:4] !o_active) else $error("still active");
    a_busy_length: assert property (@(posedge i_clock) disable iff (i_rst)
        $fell(o_write_busy) |-> busy_cnt_q >= WRITE_CYCLES - 1
        && busy_cnt_q <= WRITE_CYCLES + 1) else $error("write length");
    a_lock_kept: assert property (@(posedge i_clock) disable iff (i_rst)
        o_id_locked |=> o_id_locked) else $error("lock lost");
    a_out_on_fall: assert property (@(negedge i_sclk)
        disable iff (i_rst || i_cs_n) !o_miso_oe_n |-> o_miso == rise_bit_q)
        else $error("output moved off the falling edge");
endmodule : sep_eeprom_front_props

bind sep_eeprom_front sep_eeprom_front_props #(
    .WRITE_CYCLES(WRITE_CYCLES)
) chk_u (
    .i_clock(i_clock), .i_rst(i_rst), .i_sclk(i_sclk), .i_mosi(i_mosi),
    .i_cs_n(i_cs_n), .i_hold_n(i_hold_n), .o_miso(o_miso),
    .o_miso_oe_n(o_miso_oe_n), .o_active(o_active), .o_standby(o_standby),
    .o_write_busy(o_write_busy), .o_id_locked(o_id_locked)
);

// ==== verif/sep_spi_master.sv ====
// sep_spi_master.sv: behavioural bus master driving the memory pins
`timescale 1ns/1ps
module sep_spi_master (
    // pins towards the device
    output logic      o_sclk,
    output logic      o_mosi,
    output logic      o_cs_n,
    output logic      o_hold_n,
    // device output
    input  wire logic i_miso,
    input  wire logic i_miso_oe_n
);
    logic last_q;
    initial
    begin
        o_sclk = 1'b0;
        o_mosi = 1'b0;
        o_cs_n = 1'b0; // no select edge before first frame
        o_hold_n = 1'b1;
        last_q = 1'b0;
    end
    // ======================================================================
    // pause with clock low, clock and data toggled meanwhile
    task automatic pause();
        #20 o_hold_n = 1'b0;
        repeat (4)
        begin
            #20 o_sclk = 1'b1;
            o_mosi = ~o_mosi;
            #20 o_sclk = 1'b0;
        end
        #20 o_hold_n = 1'b1;
        #20;
    endtask : pause
    // ======================================================================
    // one mode 0 frame, msb first, 80 ns bit time
    task automatic xfer(input logic [7:0] tx[$], input int nrx,
        input int hold_at, output logic [7:0] rx[$]);
        logic [7:0] b;
        rx = {};
        #13 o_cs_n = 1'b0;
        for (int k = 0; k < tx.size() + nrx; k++)
        begin
            b = (k < tx.size()) ? tx[k] : ~b;
            for (int i = 7; i >= 0; i--)
            begin
                o_mosi = b[i];
                #40 o_sclk = 1'b1;
                last_q = i_miso_oe_n ? ~last_q : i_miso;
                b[i] = last_q;
                #40 o_sclk = 1'b0;
            end
            if (k >= tx.size())
                rx.push_back(b);
            if (k == hold_at)
                pause();
        end
        #40 o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        #200;
    endtask : xfer
endmodule : sep_spi_master

// ==== verif/sep_eeprom_front_tb.sv ====
// sep_eeprom_front_tb.sv: self-checking bench of the serial memory front end
`timescale 1ns/1ps
module sep_eeprom_front_tb;
    logic        i_clock, i_rst, sclk, mosi, cs_n, hold_n, miso, oe_n;
    logic        active, standby, busy, locked, lock_m;
    int          err_count = 0, checks = 0, cycles = 0;
    logic [31:0] seed;
    logic [15:0] a;
    logic [7:0]  mem [0:16383] = '{default: 8'h00};
    logic [7:0]  idp [0:63] = '{default: 8'h00};
    logic [7:0]  tx[$], rx[$];

    sep_eeprom_front #(.WRITE_CYCLES(20)) dut_u (
        .i_clock(i_clock), .i_rst(i_rst), .i_sclk(sclk), .i_mosi(mosi),
        .i_cs_n(cs_n), .i_hold_n(hold_n), .o_miso(miso),
        .o_miso_oe_n(oe_n), .o_active(active), .o_standby(standby),
        .o_write_busy(busy), .o_id_locked(locked));
    sep_spi_master m_u (.o_sclk(sclk), .o_mosi(mosi), .o_cs_n(cs_n),
        .o_hold_n(hold_n), .i_miso(miso), .i_miso_oe_n(oe_n));

    initial
    begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    always @(posedge i_clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            err_count = err_count + 1;
            summarize();
        end
    end
    // ======================================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic summarize();
        if (err_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    // wait for standby; exp 0 or 1 says whether a write cycle ran
    task automatic settle(input int exp);
        int n;
        bit saw;
        n = 0;
        saw = 0;
        while (n < 300 && !(standby === 1'b1 && n >= 40))
        begin
            @(posedge i_clock);
            #1;
            saw = saw | (busy === 1'b1);
            n++;
        end
        if (exp < 2)
            check({7'h00, saw}, exp[7:0]);
        check({7'h00, standby}, 8'h01);
        check({7'h00, active}, 8'h00);
        check({7'h00, locked}, {7'h00, lock_m});
    endtask : settle
    task automatic wr(input logic [7:0] op, input logic [15:0] ad,
        input int n, input int exp);
        logic [5:0] o;
        if (op == 8'h84)
            tx = {op};
        else
            tx = {op, ad[15:8], ad[7:0]};
        for (int j = 0; j < n; j++)
        begin
            seed = xs(seed);
            tx.push_back(seed[7:0]);
            o = ad[5:0] + j[5:0];
            if (exp == 1)
                mem[{ad[13:6], o}] = seed[7:0];
            if (exp == 2 && !lock_m)
                idp[o] = seed[7:0];
        end
        m_u.xfer(tx, 0, -1, rx);
        if (op == 8'h84)
            lock_m = 1'b1;
        settle(exp);
    endtask : wr
    task automatic rd(input logic [7:0] op, input logic [15:0] ad,
        input int n, input int hold);
        logic [13:0] p;
        tx = {op, ad[15:8], ad[7:0]};
        // selected device reports active while the frame runs
        fork
            m_u.xfer(tx, n, hold, rx);
            begin
                repeat (20) @(posedge i_clock);
                #1;
                check({7'h00, active}, 8'h01);
            end
        join
        for (int j = 0; j < n; j++)
        begin
            p = ad[13:0] + j[13:0];
            check(rx[j], op == 8'h03 ? mem[p] : idp[p[5:0]]);
        end
        settle(0);
    endtask : rd
    // ======================================================================
    // main sequence
    initial
    begin
        seed = 32'h8146F36B;
        lock_m = 1'b0;
        i_rst = 1'b1;
        repeat (10) @(posedge i_clock);
        i_rst <= 1'b0;
        repeat (5) @(posedge i_clock);
        wr(8'h02, 16'h0000, 2, 0);
        rd(8'h03, 16'h0000, 2, -1);
        seed = xs(seed);
        a = {seed[31:22], 6'h3E};
        wr(8'h02, a, 4, 1);
        rd(8'h03, a, 6, 4);
        wr(8'h02, 16'h3FFF, 1, 1);
        rd(8'h03, 16'h3FFF, 2, -1);
        wr(8'h82, 16'h003D, 5, 2);
        rd(8'h83, 16'h003C, 8, 5);
        wr(8'h84, 16'h0000, 0, 2);
        wr(8'h82, 16'h0000, 2, 2);
        rd(8'h83, 16'h0000, 2, -1);
        wr(8'h05, 16'h0000, 1, 0);
        for (int k = 0; k < 4; k++)
        begin
            seed = xs(seed);
            a = seed[15:0];
            wr(8'h02, a, 3, 1);
            rd(8'h03, a, 3, k + 2);
        end
        summarize();
    end
endmodule : sep_eeprom_front_tb
